// >>> design/ssx_pkg.sv
// Package for the nibble-exchange, zero-skip, table-read and xor execution unit.
// Assumes one instruction clock; operation codes are local to this unit.
package ssx_pkg;

  typedef enum logic [3:0] {
    SSX_OP_NONE     = 4'h0,
    SSX_OP_SWAP_MEM = 4'h1,
    SSX_OP_SWAP_ACC = 4'h2,
    SSX_OP_SKIP_Z   = 4'h3,
    SSX_OP_COPY_SKZ = 4'h4,
    SSX_OP_SKIP_BIT = 4'h5,
    SSX_OP_TAB_CUR  = 4'h6,
    SSX_OP_TAB_LAST = 4'h7,
    SSX_OP_XOR_ACC  = 4'h8,
    SSX_OP_XOR_MEM  = 4'h9,
    SSX_OP_XOR_IMM  = 4'ha
  } ssx_op_type;

  typedef enum logic [1:0] {
    SSX_ST_IDLE  = 2'b00,
    SSX_ST_TABLE = 2'b01,
    SSX_ST_DUMMY = 2'b10
  } ssx_state_type;

  localparam logic [7:0] SSX_ACC_RESET  = 8'h00;
  localparam logic [7:0] SSX_TABLE_HIGH_LATCH_RESET = 8'h00;
  localparam logic       SSX_Z_RESET    = 1'b0;
  localparam logic [7:0] SSX_WDATA_RESET = 8'h00;

endpackage : ssx_pkg

// >>> design/ssx_alu.sv
// Combinational data path: nibble exchange, xor and zero tests.
// Assumes operands are presented in the same cycle the result is used.
module ssx_alu (
  // Operands
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_mem,
  input  wire logic [7:0] i_imm,
  input  wire logic [2:0] i_bit_sel,
  // Results
  output logic      [7:0] o_swapped,
  output logic      [7:0] o_xor_mem,
  output logic      [7:0] o_xor_imm,
  output logic            o_mem_zero,
  output logic            o_bit_zero
);

  always_comb begin
    o_swapped  = {i_mem[3:0], i_mem[7:4]};
    o_xor_mem  = i_acc ^ i_mem;
    o_xor_imm  = i_acc ^ i_imm;
    o_mem_zero = (i_mem == 8'h00);
    o_bit_zero = ~i_mem[i_bit_sel];
  end

endmodule : ssx_alu

// >>> design/ssx_exec.sv
// Execution unit for nibble exchange, zero skips, table reads and xor.
// Assumes the core presents one decoded operation per cycle with its memory
// operand already read, and accepts a one-cycle memory write strobe back.
module ssx_exec #(
  parameter int PC_WIDTH   = 13,
  parameter bit HAS_PTR_HI = 1'b1
) (
  // Clock and reset
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RST,
  // Decoded operation
  input  wire logic                i_op_valid,
  input  ssx_pkg::ssx_op_type      i_op,
  input  wire logic [7:0]          i_mem_data,
  input  wire logic [7:0]          i_imm,
  input  wire logic [2:0]          i_bit_sel,
  // Table pointers
  input  wire logic [7:0]          i_table_pointer_low,
  input  wire logic [7:0]          i_table_pointer_high,
  // Program memory read port
  output logic [PC_WIDTH-1:0]      o_prog_addr,
  output logic                     o_prog_rd,
  input  wire logic [15:0]         i_prog_data,
  // Memory write-back
  output logic                     o_mem_we,
  output logic [7:0]               o_mem_wdata,
  // Core state
  output logic [7:0]               o_acc,
  output logic                     o_zero_flag,
  output logic [7:0]               o_table_high_latch,
  output logic                     o_busy,
  output logic                     o_skip_dummy
);

  localparam int LOW_BITS = (PC_WIDTH < 8) ? PC_WIDTH : 8;

  ssx_pkg::ssx_state_type state;
  ssx_pkg::ssx_state_type next_state;
  logic [7:0]             acc;
  logic [7:0]             next_acc;
  logic                   zero_flag;
  logic                   next_zero_flag;
  logic [7:0]             table_high_latch;
  logic [7:0]             next_table_high_latch;
  logic                   mem_we;
  logic                   next_mem_we;
  logic [7:0]             mem_wdata;
  logic [7:0]             next_mem_wdata;
  logic [PC_WIDTH-1:0]    prog_addr;
  logic [PC_WIDTH-1:0]    next_prog_addr;
  logic [7:0]             swapped;
  logic [7:0]             xor_mem;
  logic [7:0]             xor_imm;
  logic                   mem_zero;
  logic                   bit_zero;
  logic [15:0]            ptr_full;
  logic [PC_WIDTH-1:0]    addr_cur;
  logic [PC_WIDTH-1:0]    addr_last;
  logic                   op_taken;

  ssx_alu i_ssx_alu (
    .i_acc      (acc),
    .i_mem      (i_mem_data),
    .i_imm      (i_imm),
    .i_bit_sel  (i_bit_sel),
    .o_swapped  (swapped),
    .o_xor_mem  (xor_mem),
    .o_xor_imm  (xor_imm),
    .o_mem_zero (mem_zero),
    .o_bit_zero (bit_zero)
  );

  // Without a high pointer the upper bits of addr_cur stay zero; addr_last always sets them to ones
  always_comb begin
    ptr_full  = HAS_PTR_HI ? {i_table_pointer_high, i_table_pointer_low}
                           : {8'h00, i_table_pointer_low};
    addr_cur  = ptr_full[PC_WIDTH-1:0];
    addr_last = '1;
    addr_last[LOW_BITS-1:0] = i_table_pointer_low[LOW_BITS-1:0];
  end

  // Taken only while idle; an operation offered while busy is dropped
  always_comb begin
    op_taken = i_op_valid && (state == ssx_pkg::SSX_ST_IDLE);
  end

  // Sequencing group: the table fetch cycle and the dummy cycle of a skip
  always_comb begin
    next_state     = state;
    next_prog_addr = prog_addr;
    unique case (state)
      ssx_pkg::SSX_ST_IDLE: begin
        if (op_taken) begin
          unique case (i_op)
            ssx_pkg::SSX_OP_SKIP_Z: begin
              if (mem_zero) begin
                next_state = ssx_pkg::SSX_ST_DUMMY;
              end
            end
            ssx_pkg::SSX_OP_COPY_SKZ: begin
              if (mem_zero) begin
                next_state = ssx_pkg::SSX_ST_DUMMY;
              end
            end
            ssx_pkg::SSX_OP_SKIP_BIT: begin
              if (bit_zero) begin
                next_state = ssx_pkg::SSX_ST_DUMMY;
              end
            end
            ssx_pkg::SSX_OP_TAB_CUR: begin
              next_prog_addr = addr_cur;
              next_state     = ssx_pkg::SSX_ST_TABLE;
            end
            ssx_pkg::SSX_OP_TAB_LAST: begin
              next_prog_addr = addr_last;
              next_state     = ssx_pkg::SSX_ST_TABLE;
            end
            default: begin
            end
          endcase
        end
      end
      // Program word is captured at the end of the cycle in which the address is issued
      ssx_pkg::SSX_ST_TABLE: begin
        next_state = ssx_pkg::SSX_ST_IDLE;
      end
      // Dummy cycle replaces the skipped instruction
      ssx_pkg::SSX_ST_DUMMY: begin
        next_state = ssx_pkg::SSX_ST_IDLE;
      end
      default: begin
        next_state = ssx_pkg::SSX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state     <= ssx_pkg::SSX_ST_IDLE;
      prog_addr <= '0;
    end else begin
      state     <= next_state;
      prog_addr <= next_prog_addr;
    end
  end

  // Data group: accumulator, zero flag, table-high latch and write-back.
  // Only the xor operations touch the zero flag; the rest leave it alone.
  always_comb begin
    next_acc       = acc;
    next_zero_flag = zero_flag;
    next_table_high_latch      = table_high_latch;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_wdata;
    if (state == ssx_pkg::SSX_ST_TABLE) begin
      next_mem_we    = 1'b1;
      next_mem_wdata = i_prog_data[7:0];
      next_table_high_latch      = i_prog_data[15:8];
    end else if (op_taken) begin
      unique case (i_op)
        ssx_pkg::SSX_OP_SWAP_MEM: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = swapped;
        end
        ssx_pkg::SSX_OP_SWAP_ACC: begin
          next_acc = swapped;
        end
        // The copy lands whether or not the skip is taken
        ssx_pkg::SSX_OP_COPY_SKZ: begin
          next_acc = i_mem_data;
        end
        ssx_pkg::SSX_OP_XOR_ACC: begin
          next_acc       = xor_mem;
          next_zero_flag = (xor_mem == 8'h00);
        end
        ssx_pkg::SSX_OP_XOR_MEM: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = xor_mem;
          next_zero_flag = (xor_mem == 8'h00);
        end
        ssx_pkg::SSX_OP_XOR_IMM: begin
          next_acc       = xor_imm;
          next_zero_flag = (xor_imm == 8'h00);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      acc       <= ssx_pkg::SSX_ACC_RESET;
      zero_flag <= ssx_pkg::SSX_Z_RESET;
      table_high_latch      <= ssx_pkg::SSX_TABLE_HIGH_LATCH_RESET;
      mem_we    <= 1'b0;
      mem_wdata <= ssx_pkg::SSX_WDATA_RESET;
    end else begin
      acc       <= next_acc;
      zero_flag <= next_zero_flag;
      table_high_latch      <= next_table_high_latch;
      mem_we    <= next_mem_we;
      mem_wdata <= next_mem_wdata;
    end
  end

  always_comb begin
    o_acc              = acc;
    o_zero_flag        = zero_flag;
    o_table_high_latch = table_high_latch;
    o_mem_we           = mem_we;
    o_mem_wdata        = mem_wdata;
    o_prog_addr        = prog_addr;
    o_prog_rd          = (state == ssx_pkg::SSX_ST_TABLE);
    o_skip_dummy       = (state == ssx_pkg::SSX_ST_DUMMY);
    o_busy             = (state != ssx_pkg::SSX_ST_IDLE);
  end

endmodule : ssx_exec

// >>> dv/ssx_exec_asserts.sv
// Checker for the swap, skip, table and xor unit.
// Bound into ssx_exec; sees only its ports.
module ssx_exec_asserts (
  // Clock and reset
  input wire logic           I_SYS_CLK,
  input wire logic           I_RST,
  // Operation side
  input wire logic           i_op_valid,
  input ssx_pkg::ssx_op_type i_op,
  input wire logic [7:0]     i_mem_data,
  input wire logic [7:0]     i_imm,
  input wire logic [2:0]     i_bit_sel,
  input wire logic [15:0]    i_prog_data,
  // Results
  input wire logic           o_prog_rd,
  input wire logic           o_mem_we,
  input wire logic [7:0]     o_mem_wdata,
  input wire logic [7:0]     o_acc,
  input wire logic           o_zero_flag,
  input wire logic [7:0]     o_table_high_latch,
  input wire logic           o_busy,
  input wire logic           o_skip_dummy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  prev_acc;
  logic [7:0]  prev_mem;
  logic [7:0]  prev_imm;
  logic [15:0] prev_prog;
  logic        taken;

  assign taken = i_op_valid && !o_busy;

  // Last edge's causes, so each result is compared with what produced it
  always_ff @(posedge I_SYS_CLK) begin
    prev_acc  <= o_acc;
    prev_mem  <= i_mem_data;
    prev_imm  <= i_imm;
    prev_prog <= i_prog_data;
  end

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  a_swap_mem_wb: assert property (taken && i_op == ssx_pkg::SSX_OP_SWAP_MEM |=>
    o_mem_we && o_mem_wdata == {prev_mem[3:0], prev_mem[7:4]} && $stable(o_zero_flag))
    else $error("nibble exchange to memory wrote a wrong value");
  a_swap_acc_val: assert property (taken && i_op == ssx_pkg::SSX_OP_SWAP_ACC |=>
    !o_mem_we && o_acc == {prev_mem[3:0], prev_mem[7:4]} && $stable(o_zero_flag))
    else $error("nibble exchange to accumulator gave a wrong value");
  a_skip_zero_dummy: assert property (taken && i_op == ssx_pkg::SSX_OP_SKIP_Z |=>
    o_skip_dummy == (prev_mem == 8'h00) && o_busy == o_skip_dummy && !o_mem_we
    && $stable(o_zero_flag)) else $error("byte zero skip decided wrongly");
  a_copy_skip_acc: assert property (taken && i_op == ssx_pkg::SSX_OP_COPY_SKZ |=>
    o_acc == prev_mem && o_skip_dummy == (prev_mem == 8'h00) && $stable(o_zero_flag))
    else $error("copy and skip gave a wrong result");
  a_bit_skip_taken: assert property (taken && i_op == ssx_pkg::SSX_OP_SKIP_BIT
    && !i_mem_data[i_bit_sel] |=> o_skip_dummy && $stable(o_zero_flag))
    else $error("bit zero skip not taken");
  a_table_read_walk: assert property (taken &&
    i_op inside {ssx_pkg::SSX_OP_TAB_CUR, ssx_pkg::SSX_OP_TAB_LAST} |=>
    o_prog_rd && o_busy ##1 o_mem_we && o_mem_wdata == prev_prog[7:0]
    && o_table_high_latch == prev_prog[15:8] && $stable(o_zero_flag))
    else $error("table read stored a wrong word");
  a_xor_acc_zero: assert property (taken && i_op == ssx_pkg::SSX_OP_XOR_ACC |=>
    o_acc == (prev_acc ^ prev_mem) && o_zero_flag == (o_acc == 8'h00))
    else $error("xor into accumulator gave a wrong result");
  a_xor_mem_zero: assert property (taken && i_op == ssx_pkg::SSX_OP_XOR_MEM |=>
    o_mem_we && o_mem_wdata == (prev_acc ^ prev_mem) && o_acc == prev_acc
    && o_zero_flag == (o_mem_wdata == 8'h00)) else $error("xor into memory gave a wrong result");
  a_xor_imm_zero: assert property (taken && i_op == ssx_pkg::SSX_OP_XOR_IMM |=>
    !o_mem_we && o_acc == (prev_acc ^ prev_imm) && o_zero_flag == (o_acc == 8'h00))
    else $error("xor with immediate gave a wrong result");
  a_dummy_drops_op: assert property (o_skip_dummy |=>
    !o_mem_we && $stable(o_acc) && $stable(o_zero_flag))
    else $error("operation offered in the dummy cycle took effect");
  c_skip: cover property (taken && i_op == ssx_pkg::SSX_OP_SKIP_Z ##1 o_skip_dummy);
  c_table: cover property (o_prog_rd ##1 o_mem_we);
  c_zero: cover property ($rose(o_zero_flag));
  c_drop: cover property (o_skip_dummy && i_op_valid);
endmodule : ssx_exec_asserts

bind ssx_exec ssx_exec_asserts i_ssx_exec_asserts (
  .I_SYS_CLK          (I_SYS_CLK),
  .I_RST              (I_RST),
  .i_op_valid         (i_op_valid),
  .i_op               (i_op),
  .i_mem_data         (i_mem_data),
  .i_imm              (i_imm),
  .i_bit_sel          (i_bit_sel),
  .i_prog_data        (i_prog_data),
  .o_prog_rd          (o_prog_rd),
  .o_mem_we           (o_mem_we),
  .o_mem_wdata        (o_mem_wdata),
  .o_acc              (o_acc),
  .o_zero_flag        (o_zero_flag),
  .o_table_high_latch (o_table_high_latch),
  .o_busy             (o_busy),
  .o_skip_dummy       (o_skip_dummy)
);

// >>> dv/ssx_exec_bench.sv
// Self-checking bench for ssx_exec: swaps, skips, table reads, xor.
// Inputs change on the falling edge; the checker is bound in separately.
module ssx_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                vld = 1'b0;
  ssx_pkg::ssx_op_type op  = ssx_pkg::SSX_OP_NONE;
  logic [7:0]          mem = 8'h00, imm = 8'h00, lo = 8'h00, hi = 8'h00, wd, acc, lat;
  logic [2:0]          bs  = 3'h0;
  logic [15:0]         pd  = 16'h0000;
  logic [12:0]         pa;
  logic                rd, we, z, busy, dum;
  int                  num_errors = 0, comparisons = 0;
  ssx_exec i_ssx_exec (
    .I_SYS_CLK(clk), .I_RST(rst), .i_op_valid(vld), .i_op(op), .i_mem_data(mem), .i_imm(imm),
    .i_bit_sel(bs), .i_table_pointer_low(lo), .i_table_pointer_high(hi), .o_prog_addr(pa),
    .o_prog_rd(rd), .i_prog_data(pd), .o_mem_we(we), .o_mem_wdata(wd), .o_acc(acc),
    .o_zero_flag(z), .o_table_high_latch(lat), .o_busy(busy), .o_skip_dummy(dum)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One op for one cycle; returns in the cycle where its results show
  task automatic go(input ssx_pkg::ssx_op_type c, input logic [7:0] m, input logic [7:0] x);
    @(negedge clk);
    op  = c;
    mem = m;
    imm = x;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : go
  task automatic t_swap;
    chk({z, acc, lat}, 17'h00000);
    go(ssx_pkg::SSX_OP_SWAP_MEM, 8'h3c, 8'h00);
    chk({we, wd}, 9'h1c3);
    go(ssx_pkg::SSX_OP_SWAP_ACC, 8'h5a, 8'h00);
    chk({we, acc}, 9'h0a5);
  endtask : t_swap
  task automatic t_xor;
    go(ssx_pkg::SSX_OP_XOR_ACC, 8'h0f, 8'h00);
    chk({z, acc}, 9'h0aa);
    go(ssx_pkg::SSX_OP_XOR_IMM, 8'h00, 8'haa);
    chk({z, acc}, 9'h100);
    go(ssx_pkg::SSX_OP_SWAP_MEM, 8'h12, 8'h00);
    chk(z, 1'b1);
    go(ssx_pkg::SSX_OP_XOR_MEM, 8'h3c, 8'h00);
    chk({we, z, wd}, 10'h23c);
    go(ssx_pkg::SSX_OP_XOR_MEM, 8'h00, 8'h00);
    chk({we, z, wd}, 10'h300);
  endtask : t_xor
  task automatic t_skip;
    @(negedge clk);
    op  = ssx_pkg::SSX_OP_SKIP_Z;
    mem = 8'h00;
    vld = 1'b1;
    @(negedge clk);
    chk({busy, dum}, 2'h3);
    // Valid stays up into the dummy cycle, so this op must be dropped
    op  = ssx_pkg::SSX_OP_XOR_IMM;
    imm = 8'hff;
    @(negedge clk);
    vld = 1'b0;
    chk({busy, acc}, 9'h000);
    go(ssx_pkg::SSX_OP_SKIP_Z, 8'h01, 8'h00);
    chk(busy, 1'b0);
    go(ssx_pkg::SSX_OP_COPY_SKZ, 8'h00, 8'h00);
    chk({dum, acc}, 9'h100);
    go(ssx_pkg::SSX_OP_COPY_SKZ, 8'h80, 8'h00);
    chk({dum, acc}, 9'h080);
    bs = 3'h7;
    go(ssx_pkg::SSX_OP_SKIP_BIT, 8'h7f, 8'h00);
    chk(dum, 1'b1);
    go(ssx_pkg::SSX_OP_SKIP_BIT, 8'h80, 8'h00);
    chk(dum, 1'b0);
  endtask : t_skip
  task automatic t_tab;
    lo = 8'h34;
    hi = 8'h12;
    go(ssx_pkg::SSX_OP_TAB_CUR, 8'h00, 8'h00);
    chk({rd, pa}, 14'h3234);
    pd = 16'hbeef;
    @(negedge clk);
    chk({we, wd, lat}, 17'h1efbe);
    pd = 16'h5a01;
    go(ssx_pkg::SSX_OP_TAB_LAST, 8'h00, 8'h00);
    chk({rd, pa}, 14'h3f34);
    @(negedge clk);
    chk({we, wd, lat}, 17'h1015a);
  endtask : t_tab
  // Mid-run reset clears the state, and an op offered one cycle after release is taken
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk({busy, we, z, acc, lat}, 19'h00000);
    go(ssx_pkg::SSX_OP_XOR_IMM, 8'h00, 8'h5a);
    chk({z, acc}, 9'h05a);
  endtask : t_reset
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial forever #25 clk = ~clk;
  // The sequence needs under a hundred cycles; 2000 leaves wide margin
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_swap();
    t_xor();
    t_skip();
    t_tab();
    t_reset();
    wrap_up();
  end
endmodule : ssx_exec_bench
